// *** bench/tape_drive_model.sv ***
// Purpose: behavioural tape drive at the far end of the serial link
// Assumes: drive clock runs free, unrelated to the bus clock
// Notes:   status echoes the command line; read data toggles
`timescale 1ns/1ps
module tape_drive_model
    import tape_serial_pkg::*;
(
    // drive clock
    output logic           link_clk,
    // controller lines
    input wire drive_out_t drive_out_p,
    input wire drive_out_t drive_out_n,
    output drive_in_t      drive_in_p,
    output drive_in_t      drive_in_n
);
    logic rd_q = 1'b0;
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #40 link_clk = ~link_clk;
    end
    // read line never holds still, so stale data cannot pass
    always_ff @(posedge link_clk) rd_q <= ~rd_q;
    assign drive_in_p = '{status: drive_out_p.cmd & ~drive_out_n.cmd,
                          rdata: rd_q};
    assign drive_in_n = drive_in_t'(~drive_in_p);
endmodule : tape_drive_model

// *** bench/tape_drive_serial_interface_bench.sv ***
// Purpose: self-checking bench for the tape drive serial interface
// Assumes: drive model supplies the link clock
// Notes:   data loopback checked against the idle-zero write line
`timescale 1ns/1ps
module tape_drive_serial_interface_bench
    import tape_serial_pkg::*;
;
    logic aclk, aresetn, link_clk, link_rstn, drive_gap;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    drive_in_t drive_in_p, drive_in_n;
    drive_out_t drive_out_p, drive_out_n;
    logic read_dma_request, write_dma_request, host_irq_request;
    logic selftest_lamp, port_init_lamp, controller_irq;
    int fails, checks_done;

    tape_drive_serial_interface tape_drive_serial_interface_inst (.*);
    tape_drive_model tape_drive_model_inst (.*);

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tmo(input int n, input int lim);
        if (n >= lim)
        begin
            fails++;
            stop_test();
        end
    endtask : tmo
    function automatic logic [31:0] exp_misc(input logic [31:0] c);
        return {29'h0, c[2], c[1], c[0]};
    endfunction : exp_misc
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 60; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            s_axi_bready <= s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        tmo(n, 60);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 60; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            s_axi_rready <= s_axi_rvalid;
        end
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
        tmo(n, 60);
    endtask : rd

    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    initial
    begin : main
        logic [31:0] d;
        logic [31:0] v;
        logic [7:0] c;
        logic [1:0] r;
        int n;
        fails = 0;
        checks_done = 0;
        {aresetn, link_rstn, drive_gap} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        void'($urandom(11));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        link_rstn <= 1'b1;
        @(posedge aclk);
        chk(32'({selftest_lamp, port_init_lamp}), 32'h3);
        rd(ctrl_off, v, r);
        chk(v, 32'(ctrl_reset));
        for (int i = 0; i < 6; i++)
        begin
            d = (i == 0) ? 32'h07 : $urandom & 32'h37;
            wr(ctrl_off, d, r);
            @(posedge aclk);
            chk(32'({port_init_lamp, selftest_lamp}), 32'(d[5:4]));
            rd(status_off, v, r);
            chk(v & 32'h7, exp_misc(d));
            chk(32'(host_irq_request), 32'(d[2]));
            for (n = 0; n < 40 && {drive_out_p.wgate, drive_out_p.erase}
                 !== {d[0], d[1]}; n++)
                @(posedge aclk);
            tmo(n, 40);
            chk(32'(drive_out_p ^ drive_out_n), 32'hF);
        end
        wr(8'h1C, 32'hFFFFFFFF, r);
        chk(32'(r), 32'(resp_slverr));
        rd(8'h1C, v, r);
        chk(v, 32'h0);
        chk(32'(r), 32'(resp_slverr));
        c = 8'($urandom);
        wr(ctrl_off, 32'h008, r);
        wr(irq_off, 32'h800, r);
        wr(cmd_tx_off, 32'(c), r);
        for (n = 0; n < 1000 && controller_irq !== 1'b1; n++)
            @(posedge aclk);
        tmo(n, 1000);
        rd(cmd_rx_off, v, r);
        chk(v & 32'hFF, 32'(c));
        wr(irq_off, 32'h808, r);
        @(posedge aclk);
        chk(32'(controller_irq), 32'h0);
        for (int s = 1; s <= 16; s++)
        begin
            wr(ctrl_off, 32'h388, r);
            wr(ctrl_off, 32'h288, r);
            if (s == 8 || s == 15 || s == 16)
            begin
                repeat (12) @(posedge aclk);
                rd(irq_off, v, r);
                chk(32'(v[ev_gap_bit]), 32'(s == 16));
            end
        end
        rd(dma_off, v, r);
        chk(v, 32'h0);
        chk(32'(read_dma_request), 32'h1);
        wr(dma_off, 32'h700, r);
        wr(ctrl_off, 32'h0C1, r);
        for (int k = 0; k < 3; k++)
        begin
            for (n = 0; n < 1000 && write_dma_request !== 1'b1; n++)
                @(posedge aclk);
            tmo(n, 1000);
            wr(dma_off, (k == 2) ? 32'hD5A : 32'h95A, r);
        end
        repeat (200) @(posedge aclk);
        chk(32'(write_dma_request), 32'h0);
        rd(status_off, v, r);
        chk(32'(v[6:5]), 32'h3);
        chk(32'(read_dma_request), 32'h0);
        stop_test();
    end
endmodule : tape_drive_serial_interface_bench

// *** bench/tape_serial_assertions.sv ***
// Purpose: port-level checks for the tape drive serial interface
// Assumes: bound to the top module, both resets active low
// Notes:   lamp check looks only at the first edge out of reset
`timescale 1ns/1ps
module tape_serial_assertions
    import tape_serial_pkg::*;
(
    // clocks and resets
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        link_clk,
    input wire logic        link_rstn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // drive lines and lamps
    input wire drive_out_t  drive_out_p,
    input wire drive_out_t  drive_out_n,
    input wire logic        selftest_lamp,
    input wire logic        port_init_lamp,
    input wire logic        controller_irq
);
    property p_bh; @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bh: assert property (p_bh) else $error("bvalid dropped");
    property p_rh; @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rh: assert property (p_rh) else $error("read answer not held");
    property p_rv; @(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("read answer late");
    property p_bv; @(posedge aclk) disable iff (!aresetn)
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid; endproperty
    a_bv: assert property (p_bv) else $error("write answer late");
    property p_w1; @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid |-> !s_axi_awready; endproperty
    a_w1: assert property (p_w1) else $error("second write taken");
    property p_r1; @(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_arready; endproperty
    a_r1: assert property (p_r1) else $error("second read taken");
    property p_pair; @(posedge link_clk) disable iff (!link_rstn)
        drive_out_n == ~drive_out_p; endproperty
    a_pair: assert property (p_pair) else $error("pair not complement");
    property p_lamp; @(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> selftest_lamp && port_init_lamp && !controller_irq;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamps dark at reset");
endmodule : tape_serial_assertions

bind tape_drive_serial_interface tape_serial_assertions
    tape_serial_assertions_inst (.*);

// *** hdl/tape_drive_serial_interface.sv ***
// Purpose: serial interface to a cartridge tape drive
// Assumes: drive clocks arrive on link_clk, one clock per byte bit
// Notes:   dma handshake runs as register strobes from software
`timescale 1ns/1ps
module tape_drive_serial_interface
    import tape_serial_pkg::*;
(
    // system
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // drive link, clock from drive (read or write clock)
    input  wire logic        link_clk,
    input  wire logic        link_rstn,
    input  wire drive_in_t   drive_in_p,
    input  wire drive_in_t   drive_in_n,
    output drive_out_t       drive_out_p,
    output drive_out_t       drive_out_n,
    input  wire logic        drive_gap,
    // processor-side dma and status
    output logic             read_dma_request,
    output logic             write_dma_request,
    output logic             host_irq_request,
    output logic             selftest_lamp,
    output logic             port_init_lamp,
    output logic             controller_irq
);

    // register state
    logic [9:0]  ctrl_q;
    logic [3:0]  ev_q;
    logic [3:0]  ev_mask_q;
    logic [7:0]  cmd_rx_q;
    logic [7:0]  wr_byte_q;
    logic [7:0]  rd_byte_q;
    logic        tc_rd_q;
    logic        tc_wr_q;
    logic        aw_held_q, w_held_q;
    logic [7:0]  aw_q;
    logic [31:0] w_q;
    logic [3:0]  ws_q;
    logic [7:0]  cmd_tx_word_q;
    logic        ct_tog_q;

    wire wgate    = ctrl_q[ctrl_wgate_bit];
    wire loop_sel = ctrl_q[ctrl_loop_bit];
    wire do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    // write address/data capture in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_q      <= 8'h00;
            w_q       <= 32'h0000_0000;
            ws_q      <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_q      <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                w_q      <= s_axi_wdata;
                ws_q     <= s_axi_wstrb;
            end
            else if (do_write)
                w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awready <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wready <= 1'b0;
        end
    end

    function automatic logic known(input logic [7:0] a);
        known = (a == ctrl_off) || (a == status_off) || (a == cmd_tx_off)
             || (a == cmd_rx_off) || (a == dma_off) || (a == irq_off);
    endfunction : known

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= resp_okay;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known(aw_q) ? resp_okay : resp_slverr;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    wire wr_ctrl = do_write && aw_q == ctrl_off && ws_q[0];
    wire wr_cmd  = do_write && aw_q == cmd_tx_off && ws_q[0];
    wire wr_dma  = do_write && aw_q == dma_off;
    wire wr_irq  = do_write && aw_q == irq_off && ws_q[0];

    // control bits; lamps lit out of reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_q <= ctrl_reset;
        else if (wr_ctrl)
        begin
            ctrl_q[7:0] <= w_q[7:0];
            if (ws_q[1])
                ctrl_q[9:8] <= w_q[9:8];
        end
    end

    // link side synchronisers
    logic [1:0] wg_s, loop_s, tclk_s, gsel_s, ct_s, erase_s;
    logic [1:0] st_s, rdat_s;
    logic       tclk_d1;
    logic [7:0] cmd_sh_q, wr_sh_q, rd_sh_q, cmd_buf_q;
    logic [7:0] rx_buf_q;
    logic [2:0] rd_bits_q, wr_bits_q;
    logic [3:0] cmd_bit_q, st_bit_q;
    logic [4:0] cmd_div_q, st_div_q;
    logic [7:0] st_sh_q;
    logic       cmd_line_q, data_line_q;
    logic       ct_l_q;
    logic       rx_t_q, tx_t_q, st_t_q;
    logic [2:0] gap_cnt_q;
    logic       gap_ff_q;

    always_ff @(posedge link_clk)
    begin
        wg_s   <= {wg_s[0], wgate};
        loop_s <= {loop_s[0], loop_sel};
        tclk_s <= {tclk_s[0], ctrl_q[ctrl_tclk_bit]};
        gsel_s <= {gsel_s[0], ctrl_q[ctrl_gapsel_bit]};
        erase_s <= {erase_s[0], ctrl_q[ctrl_erase_bit]};
        ct_s   <= {ct_s[0], ct_tog_q};
        st_s   <= {st_s[0], drive_in_p.status & ~drive_in_n.status};
        rdat_s <= {rdat_s[0], drive_in_p.rdata & ~drive_in_n.rdata};
    end

    // test clock stands in for drive clocks in loopback
    wire step  = loop_s[1] ? (tclk_s[1] & ~tclk_d1) : 1'b1;
    wire s_in  = loop_s[1] ? cmd_line_q : st_s[1];
    wire d_in  = loop_s[1] ? data_line_q : rdat_s[1];

    always_ff @(posedge link_clk)
    begin
        if (!link_rstn)
        begin
            tclk_d1     <= 1'b0;
            rd_sh_q     <= 8'h00;
            rx_buf_q    <= 8'h00;
            rd_bits_q   <= 3'h0;
            rx_t_q      <= 1'b0;
            wr_sh_q     <= 8'h00;
            wr_bits_q   <= 3'h0;
            tx_t_q      <= 1'b0;
            data_line_q <= 1'b1;
        end
        else
        begin
            tclk_d1 <= tclk_s[1];
            // synchronous data channel, one bit per step
            if (step && !(wg_s[1] || loop_s[1]))
            begin
                rd_sh_q   <= {rd_sh_q[6:0], d_in};
                rd_bits_q <= rd_bits_q + 3'h1;
                if (rd_bits_q == 3'h7)
                begin
                    rx_buf_q <= {rd_sh_q[6:0], d_in};
                    rx_t_q   <= ~rx_t_q;
                end
            end
            if (step && (wg_s[1] || loop_s[1]))
            begin
                // write clock times serial write data
                data_line_q <= wr_sh_q[7];
                rd_sh_q     <= {rd_sh_q[6:0], d_in};
                rd_bits_q   <= rd_bits_q + 3'h1;
                wr_bits_q   <= wr_bits_q + 3'h1;
                if (wr_bits_q == 3'h7)
                begin
                    wr_sh_q <= wr_byte_q;
                    tx_t_q  <= ~tx_t_q;
                end
                else
                    wr_sh_q <= {wr_sh_q[6:0], 1'b0};
                if (rd_bits_q == 3'h7)
                begin
                    rx_buf_q <= {rd_sh_q[6:0], d_in};
                    rx_t_q   <= ~rx_t_q;
                end
            end
        end
    end

    // async channel: baud from link clock, never the test step
    always_ff @(posedge link_clk)
    begin
        if (!link_rstn)
        begin
            cmd_line_q <= 1'b1;
            cmd_sh_q   <= 8'h00;
            cmd_bit_q  <= 4'h0;
            cmd_div_q  <= 5'h00;
            ct_l_q     <= 1'b0;
            st_bit_q   <= 4'h0;
            st_div_q   <= 5'h00;
            st_sh_q    <= 8'h00;
            st_t_q     <= 1'b0;
            cmd_buf_q  <= 8'h00;
        end
        else
        begin
            ct_l_q <= ct_s[1];
            if (ct_s[1] != ct_l_q && cmd_bit_q == 4'h0)
            begin
                cmd_sh_q  <= cmd_tx_word_q;
                cmd_bit_q <= 4'hA;
                cmd_div_q <= 5'h00;
            end
            else if (cmd_bit_q != 4'h0)
            begin
                cmd_div_q <= cmd_div_q + 5'h01;
                if (cmd_div_q == 5'(baud_div - 1))
                begin
                    cmd_div_q <= 5'h00;
                    cmd_bit_q <= cmd_bit_q - 4'h1;
                    if (cmd_bit_q == 4'hA)
                        cmd_line_q <= 1'b0;
                    else if (cmd_bit_q == 4'h1)
                        cmd_line_q <= 1'b1;
                    else
                    begin
                        cmd_line_q <= cmd_sh_q[0];
                        cmd_sh_q   <= {1'b1, cmd_sh_q[7:1]};
                    end
                end
            end
            if (st_bit_q == 4'h0 && !s_in)
            begin
                st_bit_q <= 4'hA;
                st_div_q <= 5'(baud_div / 2);
            end
            else if (st_bit_q != 4'h0)
            begin
                st_div_q <= st_div_q + 5'h01;
                if (st_div_q == 5'(baud_div - 1))
                begin
                    st_div_q <= 5'h00;
                    st_bit_q <= st_bit_q - 4'h1;
                    if (st_bit_q == 4'h1)
                    begin
                        cmd_buf_q <= st_sh_q;
                        st_t_q    <= ~st_t_q;
                    end
                    else if (st_bit_q != 4'hA)
                        st_sh_q <= {s_in, st_sh_q[7:1]};
                end
            end
        end
    end

    // gap counter clocked by gated test clock
    always_ff @(posedge link_clk)
    begin
        if (!link_rstn)
        begin
            gap_cnt_q <= 3'h0;
            gap_ff_q  <= 1'b0;
        end
        else if (gsel_s[1] && loop_s[1] && step)
        begin
            gap_cnt_q <= gap_cnt_q + 3'h1;
            if (gap_cnt_q == 3'(gap_count - 1))
                gap_ff_q <= ~gap_ff_q;
        end
    end

    // drive outputs as line pairs
    always_ff @(posedge link_clk)
    begin
        if (!link_rstn)
        begin
            drive_out_p <= '{wgate: 1'b0, erase: 1'b0, cmd: 1'b1,
                             wdata: 1'b1};
            drive_out_n <= '{wgate: 1'b1, erase: 1'b1, cmd: 1'b0,
                             wdata: 1'b0};
        end
        else
        begin
            drive_out_p.wgate <= wg_s[1];
            drive_out_n.wgate <= ~wg_s[1];
            drive_out_p.erase <= erase_s[1];
            drive_out_n.erase <= ~erase_s[1];
            drive_out_p.cmd   <= cmd_line_q;
            drive_out_n.cmd   <= ~cmd_line_q;
            drive_out_p.wdata <= data_line_q;
            drive_out_n.wdata <= ~data_line_q;
        end
    end

    // system side: crossings back, dma and events
    logic [2:0] rx_y, tx_y, st_y, gp_y, g2_y;
    always_ff @(posedge aclk)
    begin
        rx_y <= {rx_y[1:0], rx_t_q};
        tx_y <= {tx_y[1:0], tx_t_q};
        st_y <= {st_y[1:0], st_t_q};
        gp_y <= {gp_y[1:0], gap_ff_q};
        g2_y <= {g2_y[1:0], drive_gap};
    end
    wire rx_ev  = rx_y[2] != rx_y[1];
    wire tx_ev  = tx_y[2] != tx_y[1];
    wire st_ev  = st_y[2] != st_y[1];
    // gap level combined only after both sources are synchronised
    wire gap_fall = (gp_y[2] ^ g2_y[2]) && !(gp_y[1] ^ g2_y[1]);

    dma_state_t rd_state_q, wr_state_q;
    logic       first_q;

    // dma: request per byte until terminal count
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_state_q <= dma_idle;
            wr_state_q <= dma_idle;
            read_dma_request  <= 1'b0;
            write_dma_request <= 1'b0;
            rd_byte_q  <= 8'h00;
            wr_byte_q  <= 8'h00;
            first_q    <= 1'b1;
            tc_rd_q    <= 1'b0;
            tc_wr_q    <= 1'b0;
        end
        else
        begin
            if (rx_ev && ctrl_q[ctrl_rd_bit] && !tc_rd_q)
            begin
                rd_byte_q        <= rx_buf_q;
                read_dma_request <= 1'b1;
                rd_state_q       <= dma_req;
            end
            else if (wr_dma && w_q[8] && w_q[9])
            begin
                // acknowledge with read strobe drops request, latches terminal count
                read_dma_request <= 1'b0;
                rd_state_q       <= dma_idle;
                tc_rd_q          <= w_q[10];
            end
            if (ctrl_q[ctrl_wr_bit] && !tc_wr_q && wr_state_q == dma_idle
                && (tx_ev || first_q))
            begin
                write_dma_request <= 1'b1;
                wr_state_q        <= dma_req;
                first_q           <= 1'b0;
            end
            else if (wr_dma && w_q[8] && w_q[11])
            begin
                wr_byte_q         <= w_q[7:0];
                write_dma_request <= 1'b0;
                wr_state_q        <= dma_idle;
                tc_wr_q           <= w_q[10];
            end
            if (wr_ctrl && !w_q[ctrl_wr_bit])
            begin
                first_q <= 1'b1;
                tc_wr_q <= 1'b0;
            end
            if (wr_ctrl && !w_q[ctrl_rd_bit])
                tc_rd_q <= 1'b0;
        end
    end

    // command tx holding word, toggle to link
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cmd_tx_word_q <= 8'h00;
            ct_tog_q      <= 1'b0;
            cmd_rx_q      <= 8'h00;
        end
        else
        begin
            if (wr_cmd)
            begin
                cmd_tx_word_q <= w_q[7:0];
                ct_tog_q      <= ~ct_tog_q;
            end
            if (st_ev)
                cmd_rx_q <= cmd_buf_q;
        end
    end

    // sticky events: set wins over clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ev_q      <= 4'h0;
            ev_mask_q <= 4'h0;
        end
        else
        begin
            if (wr_irq)
                ev_q <= ev_q & ~w_q[3:0];
            if (do_write && aw_q == irq_off && ws_q[1])
                ev_mask_q <= w_q[11:8];
            if (gap_fall)
                ev_q[ev_gap_bit] <= 1'b1;
            if (rx_ev && rd_state_q == dma_idle && !read_dma_request)
                ev_q[ev_first_bit] <= 1'b1;
            if (tx_ev)
                ev_q[ev_txe_bit] <= 1'b1;
            if (st_ev)
                ev_q[ev_cmdrx_bit] <= 1'b1;
        end
    end

    // outputs and read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            host_irq_request <= 1'b0;
            selftest_lamp    <= 1'b1;
            port_init_lamp   <= 1'b1;
            controller_irq   <= 1'b0;
        end
        else
        begin
            host_irq_request <= ctrl_q[ctrl_hirq_bit];
            selftest_lamp    <= ctrl_q[ctrl_lamp1_bit];
            port_init_lamp   <= ctrl_q[ctrl_lamp2_bit];
            controller_irq   <= |(ev_q & ev_mask_q);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= resp_okay;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= known(s_axi_araddr) ? resp_okay
                                                     : resp_slverr;
                unique case (s_axi_araddr)
                    ctrl_off:   s_axi_rdata <= {22'h0, ctrl_q};
                    status_off: s_axi_rdata <= {25'h0, tc_wr_q, tc_rd_q,
                                    write_dma_request, read_dma_request,
                                    host_irq_request, ctrl_q[1:0]};
                    cmd_rx_off: s_axi_rdata <= {24'h0, cmd_rx_q};
                    dma_off:    s_axi_rdata <= {24'h0, rd_byte_q};
                    irq_off:    s_axi_rdata <= {20'h0, ev_mask_q, 4'h0,
                                                ev_q};
                    default:    s_axi_rdata <= 32'h0000_0000;
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule : tape_drive_serial_interface

// *** hdl/tape_serial_pkg.sv ***
// Purpose: shared constants and types for the tape drive serial interface
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz aclk
// Notes:   register offsets are byte addresses
package tape_serial_pkg;

    localparam logic [7:0] ctrl_off     = 8'h00;
    localparam logic [7:0] status_off   = 8'h04;
    localparam logic [7:0] cmd_tx_off   = 8'h08;
    localparam logic [7:0] cmd_rx_off   = 8'h0C;
    localparam logic [7:0] dma_off      = 8'h10;
    localparam logic [7:0] irq_off      = 8'h14;

    // ctrl fields
    localparam int ctrl_wgate_bit   = 0;
    localparam int ctrl_erase_bit   = 1;
    localparam int ctrl_hirq_bit    = 2;
    localparam int ctrl_loop_bit    = 3;
    localparam int ctrl_lamp1_bit   = 4;
    localparam int ctrl_lamp2_bit   = 5;
    localparam int ctrl_wr_bit      = 6;
    localparam int ctrl_rd_bit      = 7;
    localparam int ctrl_tclk_bit    = 8;
    localparam int ctrl_gapsel_bit  = 9;
    localparam logic [9:0] ctrl_reset = 10'h030;

    // event bits
    localparam int ev_gap_bit       = 0;
    localparam int ev_first_bit     = 1;
    localparam int ev_txe_bit       = 2;
    localparam int ev_cmdrx_bit     = 3;

    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    localparam int gap_count         = 8;
    localparam int baud_div          = 16;

    typedef struct packed {
        logic wgate;
        logic erase;
        logic cmd;
        logic wdata;
    } drive_out_t;

    typedef struct packed {
        logic status;
        logic rdata;
    } drive_in_t;

    typedef enum logic [1:0] {
        dma_idle,
        dma_req,
        dma_ack
    } dma_state_t;

endpackage : tape_serial_pkg
